// ---- core/flash_protect_defs.vh ----
`ifndef FLASH_PROTECT_DEFS_VH
`define FLASH_PROTECT_DEFS_VH

// register indices; byte address is four times the index
`define IDX_CTRL_STATUS 8'h2f
`define IDX_OPTION 8'h30
`define IDX_STATUS 8'h31
`define IDX_PIN_CFG 8'h32

// control/status field positions
`define BIT_OPTION_AREA_SELECT 2
`define BIT_LATCH_CONTROL 1
`define BIT_PROGRAM_CONTROL 0
`define CTRL_STATUS_RESET 3'h0

// register access key sequence
`define KEY_FIRST 8'h56
`define KEY_SECOND 8'hae

// option image field positions
`define BIT_OPT_READOUT_LOCK 0
`define BIT_OPT_WRITE_LOCK 1
`define BIT_OPT_PRECISION_RC 2
`define OPTION_RESET 3'h0

// status field positions
`define BIT_ST_SESSION 0
`define BIT_ST_MODE_OPT 1
`define BIT_ST_MODE_EXT 2
`define BIT_ST_READOUT 3
`define BIT_ST_WRITE 4
`define BIT_ST_ERASE 5
`define BIT_ST_REJECT 6
`define BIT_ST_UNLOCKED 7

// pin configuration field positions
`define BIT_PIN_CLK_OE 0
`define BIT_PIN_CLK_OUT 1
`define BIT_PIN_DATA_OE 2
`define BIT_PIN_DATA_OUT 3
`define PIN_CFG_RESET 4'h0

// entry pulse counts
`define PULSES_WITH_OPTIONS 6'd38
`define PULSES_NO_OPTIONS 6'd35

// clock source select codes
`define CLK_SEL_NORMAL 2'h0
`define CLK_SEL_PRECISION_RC 2'h1
`define CLK_SEL_WAKEUP_RC 2'h2
`define CLK_SEL_EXTERNAL 2'h3

`endif

// ---- core/pin_sync.v ----
`timescale 1ns/1ps
// two flop synchroniser for a group of level inputs
module pin_sync
(
  // clock and reset
  input wire clk,
  input wire rst,
  // asynchronous levels and their synchronised copies
  input wire [3:0] async_in,
  output reg [3:0] sync_out
);

  reg [3:0] meta_q;

  // first stage feeds only the second stage
  always @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= 4'h0;
      sync_out <= 4'h0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ---- core/flash_protect_prog_access.v ----
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "flash_protect_defs.vh"

// Operation
// - read-out and write/erase protection are separate, each enabled alone.
// - read-out lock blocks program extraction and refuses flash array writes.
// - clearing read-out lock erases all program memory, then reprogrammable.
// - one read-out lock bit in the option image controls read-out protection.
// - write/erase lock rejects every program or erase of program memory; code still mass-erases when read-out lock is cleared.
// - write/erase lock, once set, can never be cleared again; code reloads it from option_nv at every reset.
// - one write lock bit in the option image enables write/erase protection.
// - control/status is eight bits, resets zero, bits 7..3 read zero.
// - control/status writes need key 56h then key AEh first.
// - control/status only drives flash programming and erase operations.
// - 38-pulse entry forces precision RC if selected, else wake-up RC.
// - 35-pulse entry runs device from the tool's external clock input.
// - any reset returns serial clock pin to input with pull-up.
// - with tool connected, clock and data pins unavailable to application.
// - pulses on clock/data with reset low enter session, dedicated vector.
// - self-programming refuses writes and erases to sector 0.
module flash_protect_prog_access
(
  // clock and reset
  input wire clk,
  input wire rst,
  // avalon-mm slave
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  // programming link pins, asynchronous
  input wire prog_serial_clock_in,
  input wire prog_serial_data_in,
  input wire reset_pin_n,
  input wire tool_present,
  // serial clock pin drive
  output wire prog_serial_clock_out,
  output wire prog_serial_clock_oe,
  output wire prog_serial_clock_pullup,
  // serial data pin drive
  output wire prog_serial_data_out,
  output wire prog_serial_data_oe,
  output wire prog_serial_data_pullup,
  output wire pins_unavailable,
  // nonvolatile option image, stable levels
  input wire [2:0] option_nv,
  // session and clock control
  output wire incircuit_comm_active,
  output wire boot_system_vector,
  output wire [1:0] clock_source_sel,
  // flash array interface
  input wire target_in_sector0,
  output reg flash_op_start_q,
  output reg flash_op_option_q,
  output reg [2:0] option_prog_data_q,
  input wire flash_op_done,
  output reg mass_erase_start_q,
  input wire mass_erase_done,
  output wire readout_block
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_COUNT = 3'b010;
  localparam [2:0] ST_SESSION = 3'b100;
  localparam [2:0] KEY_LOCKED = 3'b001;
  localparam [2:0] KEY_HALF = 3'b010;
  localparam [2:0] KEY_OPEN = 3'b100;

  reg ack_q;
  reg [31:0] rdata_q;
  reg [2:0] ctrl_q;
  reg [2:0] key_q;
  reg [2:0] option_q;
  reg [3:0] pin_cfg_q;
  reg loaded_q;
  reg rdlock_q;
  reg wrlock_q;
  reg erase_busy_q;
  reg reject_q;
  reg [2:0] state_q;
  reg [5:0] pulse_cnt_q;
  reg mode_opt_q;
  reg mode_ext_q;
  reg sclk_prev_q;
  reg rpin_prev_q;
  reg [7:0] status_w;
  reg [31:0] rdata_d;
  wire [3:0] pins_sync;
  wire sclk_s;
  wire rpin_n_s;
  wire tool_s;
  wire bus_req;
  wire wr_en;
  wire [7:0] wr_byte;
  wire [7:0] wr_idx;
  wire start_req;
  wire op_reject;
  wire session;

  // word index from byte address
  function [7:0] word_index;
    input [9:0] addr;
    begin
      word_index = addr[9:2];
    end
  endfunction

  // pins cross into the core clock before any use
  pin_sync sync_i
  (
    .clk(clk),
    .rst(rst),
    .async_in({tool_present, reset_pin_n, prog_serial_data_in,
      prog_serial_clock_in}),
    .sync_out(pins_sync)
  );

  assign sclk_s = pins_sync[0];
  assign rpin_n_s = pins_sync[2];
  assign tool_s = pins_sync[3];

  // one wait state: read data is ready at the releasing edge
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_q;
  assign avs_readdata = rdata_q;
  assign wr_en = avs_write & ack_q & avs_byteenable[0];
  assign wr_byte = avs_writedata[7:0];
  assign wr_idx = word_index(avs_address);

  always @(posedge clk)
  begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= bus_req & ~ack_q;
  end

  // status view of the block's own state
  always @*
  begin
    status_w = 8'h00;
    status_w[`BIT_ST_SESSION] = session;
    status_w[`BIT_ST_MODE_OPT] = mode_opt_q;
    status_w[`BIT_ST_MODE_EXT] = mode_ext_q;
    status_w[`BIT_ST_READOUT] = rdlock_q;
    status_w[`BIT_ST_WRITE] = wrlock_q;
    status_w[`BIT_ST_ERASE] = erase_busy_q;
    status_w[`BIT_ST_REJECT] = reject_q;
    status_w[`BIT_ST_UNLOCKED] = key_q[2];
  end

  // read mux; unmapped words read zero
  always @*
  begin
    rdata_d = 32'h0;
    case (wr_idx)
      `IDX_CTRL_STATUS: rdata_d = {29'h0, ctrl_q};
      `IDX_OPTION: rdata_d = {29'h0, option_q};
      `IDX_STATUS: rdata_d = {24'h0, status_w};
      `IDX_PIN_CFG: rdata_d = {28'h0, pin_cfg_q};
      default: rdata_d = 32'h0;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
      rdata_q <= 32'h0;
    else if (avs_read & ~ack_q)
      rdata_q <= rdata_d;
  end

  // key sequence guards the control/status register
  always @(posedge clk)
  begin
    if (rst)
      key_q <= KEY_LOCKED;
    else if (wr_en && wr_idx == `IDX_CTRL_STATUS)
    begin
      case (key_q)
        KEY_LOCKED: key_q <= (wr_byte == `KEY_FIRST)
          ? KEY_HALF : KEY_LOCKED;
        KEY_HALF: key_q <= (wr_byte == `KEY_SECOND)
          ? KEY_OPEN : KEY_LOCKED;
        KEY_OPEN: key_q <= KEY_OPEN;
        default: key_q <= KEY_LOCKED;
      endcase
    end
  end

  // a new program/erase request: program bit rising on an open write
  assign start_req = wr_en && wr_idx == `IDX_CTRL_STATUS && key_q == KEY_OPEN
    && wr_byte[`BIT_PROGRAM_CONTROL] && !ctrl_q[`BIT_PROGRAM_CONTROL]
    && !erase_busy_q;

  // option area stays writable so that read-out lock can be removed
  assign op_reject = !wr_byte[`BIT_OPTION_AREA_SELECT]
    && (rdlock_q
    || wrlock_q
    || (!session && target_in_sector0));

  // control/status: only flash program and erase control lives here
  always @(posedge clk)
  begin
    if (rst)
      ctrl_q <= `CTRL_STATUS_RESET;
    else if (wr_en && wr_idx == `IDX_CTRL_STATUS && key_q == KEY_OPEN)
    begin
      ctrl_q[`BIT_OPTION_AREA_SELECT] <= wr_byte[`BIT_OPTION_AREA_SELECT];
      ctrl_q[`BIT_LATCH_CONTROL] <= wr_byte[`BIT_LATCH_CONTROL];
      // program bit is set only by an accepted request
      if (start_req && !op_reject)
        ctrl_q[`BIT_PROGRAM_CONTROL] <= 1'b1;
      else if (!wr_byte[`BIT_PROGRAM_CONTROL] || flash_op_done)
        ctrl_q[`BIT_PROGRAM_CONTROL] <= 1'b0;
    end
    else if (flash_op_done)
      ctrl_q[`BIT_PROGRAM_CONTROL] <= 1'b0;
  end

  // request pulses towards the flash array
  always @(posedge clk)
  begin
    if (rst)
    begin
      flash_op_start_q <= 1'b0;
      flash_op_option_q <= 1'b0;
      option_prog_data_q <= `OPTION_RESET;
    end
    else
    begin
      flash_op_start_q <= start_req & ~op_reject;
      if (start_req && !op_reject)
      begin
        flash_op_option_q <= wr_byte[`BIT_OPTION_AREA_SELECT];
        option_prog_data_q <= option_q;
      end
    end
  end

  // sticky reject flag; write one clears, a new reject wins
  always @(posedge clk)
  begin
    if (rst)
      reject_q <= 1'b0;
    else if (start_req && op_reject)
      reject_q <= 1'b1;
    else if (wr_en && wr_idx == `IDX_STATUS && wr_byte[`BIT_ST_REJECT])
      reject_q <= 1'b0;
  end

  // option staging and pin configuration registers
  always @(posedge clk)
  begin
    if (rst)
    begin
      option_q <= `OPTION_RESET;
      pin_cfg_q <= `PIN_CFG_RESET;
    end
    else if (wr_en)
    begin
      if (wr_idx == `IDX_OPTION)
        option_q <= wr_byte[2:0];
      if (wr_idx == `IDX_PIN_CFG)
        pin_cfg_q <= wr_byte[3:0];
    end
  end

  // protection state: caught once after reset, then updated by option writes
  always @(posedge clk)
  begin
    if (rst)
    begin
      loaded_q <= 1'b0;
      rdlock_q <= 1'b1;
      wrlock_q <= 1'b1;
      erase_busy_q <= 1'b0;
      mass_erase_start_q <= 1'b0;
    end
    else
    begin
      mass_erase_start_q <= 1'b0;
      if (!loaded_q)
      begin
        loaded_q <= 1'b1;
        rdlock_q <= option_nv[`BIT_OPT_READOUT_LOCK];
        wrlock_q <= option_nv[`BIT_OPT_WRITE_LOCK];
      end
      else if (start_req && !op_reject
        && wr_byte[`BIT_OPTION_AREA_SELECT])
      begin
        // locks change independently of each other
        if (option_q[`BIT_OPT_WRITE_LOCK])
          wrlock_q <= 1'b1;
        if (option_q[`BIT_OPT_READOUT_LOCK])
          rdlock_q <= 1'b1;
        else if (rdlock_q)
        begin
          erase_busy_q <= 1'b1;
          mass_erase_start_q <= 1'b1;
        end
      end
      else if (erase_busy_q && mass_erase_done)
      begin
        erase_busy_q <= 1'b0;
        rdlock_q <= 1'b0;
      end
      // write lock is cleared only by the reload from option_nv after reset
    end
  end

  assign readout_block = rdlock_q | erase_busy_q;

  // entry sequence: count clock pulses while the reset pin is low
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      pulse_cnt_q <= 6'd0;
      mode_opt_q <= 1'b0;
      mode_ext_q <= 1'b0;
      sclk_prev_q <= 1'b1;
      rpin_prev_q <= 1'b1;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      rpin_prev_q <= rpin_n_s;
      case (state_q)
        ST_IDLE:
        begin
          pulse_cnt_q <= 6'd0;
          if (!rpin_n_s && tool_s)
            state_q <= ST_COUNT;
        end
        ST_COUNT:
        begin
          if (sclk_s && !sclk_prev_q && pulse_cnt_q != 6'h3f)
            pulse_cnt_q <= pulse_cnt_q + 6'd1;
          if (rpin_n_s && !rpin_prev_q)
          begin
            if (pulse_cnt_q == `PULSES_WITH_OPTIONS)
            begin
              state_q <= ST_SESSION;
              mode_opt_q <= 1'b1;
            end
            else if (pulse_cnt_q == `PULSES_NO_OPTIONS)
            begin
              state_q <= ST_SESSION;
              mode_ext_q <= 1'b1;
            end
            else
              state_q <= ST_IDLE;
          end
        end
        // tool keeps reset pin, so session ends only at device reset
        ST_SESSION: state_q <= ST_SESSION;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign session = state_q[2];
  assign incircuit_comm_active = session;
  assign boot_system_vector = session;

  // internal rc forced in option mode, tool clock in the other
  assign clock_source_sel = !session ? `CLK_SEL_NORMAL :
    mode_ext_q ? `CLK_SEL_EXTERNAL :
    option_nv[`BIT_OPT_PRECISION_RC] ? `CLK_SEL_PRECISION_RC :
    `CLK_SEL_WAKEUP_RC;

  // tool presence takes the pins away from the application
  assign pins_unavailable = tool_s | session;

  // drive released under reset or tool; pull-up whenever not driven
  assign prog_serial_clock_oe = !rst && !pins_unavailable
    && pin_cfg_q[`BIT_PIN_CLK_OE];
  assign prog_serial_clock_out = pin_cfg_q[`BIT_PIN_CLK_OUT];
  assign prog_serial_clock_pullup = !prog_serial_clock_oe;
  assign prog_serial_data_oe = !rst && !pins_unavailable
    && pin_cfg_q[`BIT_PIN_DATA_OE];
  assign prog_serial_data_out = pin_cfg_q[`BIT_PIN_DATA_OUT];
  assign prog_serial_data_pullup = !prog_serial_data_oe;

endmodule

// ---- verif/flash_protect_prog_access_properties.sv ----
`timescale 1ns/1ps
`include "flash_protect_defs.vh"
module flash_protect_prog_access_properties
(
  // clock and reset
  input wire clk,
  input wire rst,
  // link pins and session
  input wire prog_serial_clock_oe,
  input wire prog_serial_clock_pullup,
  input wire pins_unavailable,
  input wire incircuit_comm_active,
  input wire boot_system_vector,
  input wire [1:0] clock_source_sel,
  // flash array side
  input wire target_in_sector0,
  input wire flash_op_start_q,
  input wire flash_op_option_q,
  input wire mass_erase_start_q,
  input wire readout_block
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // pin back to input with pull-up straight out of any reset
  a_pin_release: assert property (
    $fell(rst) |-> !prog_serial_clock_oe && prog_serial_clock_pullup)
    else $error("clock pin still driven after reset");
  a_session_pins: assert property (
    incircuit_comm_active |-> pins_unavailable && boot_system_vector)
    else $error("session without pin claim or boot vector");
  // a session is left only through a device reset
  a_session_holds: assert property (
    incircuit_comm_active |=> incircuit_comm_active)
    else $error("session dropped without reset");
  a_start_pulse: assert property (
    flash_op_start_q |=> !flash_op_start_q)
    else $error("flash start longer than one cycle");
  a_readout_refuse: assert property (
    flash_op_start_q && !flash_op_option_q |-> !readout_block)
    else $error("array op started under read-out lock");
  // target address is judged at the accepting edge, one cycle back
  a_sector_refuse: assert property (
    flash_op_start_q && !flash_op_option_q && !incircuit_comm_active
    |-> !$past(target_in_sector0))
    else $error("sector 0 op started outside a session");
  a_erase_busy: assert property (
    mass_erase_start_q |=> !mass_erase_start_q && readout_block)
    else $error("erase pulse wrong or protection lifted early");
  a_clock_forced: assert property (
    clock_source_sel != `CLK_SEL_NORMAL |-> incircuit_comm_active)
    else $error("clock source forced outside a session");

  c_external: cover property (clock_source_sel == `CLK_SEL_EXTERNAL);
  c_start: cover property (flash_op_start_q);
  c_erase: cover property (mass_erase_start_q);
endmodule

// ---- verif/prog_tool_model.sv ----
`timescale 1ns/1ps
// programming tool: owns the reset pin and plays the entry pulses
module prog_tool_model
(
  // link pins as seen by the device
  output logic prog_serial_clock_in,
  output logic prog_serial_data_in,
  output logic reset_pin_n,
  output logic tool_present
);
  // released lines rest at pull-up level, clock stands still
  initial
  begin
    prog_serial_clock_in = 1'b1;
    prog_serial_data_in = 1'b1;
    reset_pin_n = 1'b1;
    tool_present = 1'b0;
  end
  // reset held low over the whole train, 160 ns link period
  task enter(input int n);
    begin
      tool_present <= 1'b1;
      reset_pin_n <= 1'b0;
      #400;
      repeat (n)
      begin
        prog_serial_clock_in <= 1'b0;
        prog_serial_data_in <= ~prog_serial_data_in;
        #80;
        prog_serial_clock_in <= 1'b1;
        #80;
      end
      prog_serial_data_in <= 1'b1;
      #400;
      reset_pin_n <= 1'b1;
      #400;
    end
  endtask
endmodule

// ---- verif/flash_protect_prog_access_test.sv ----
`timescale 1ns/1ps
`include "flash_protect_defs.vh"
module flash_protect_prog_access_test;
  localparam logic [9:0] a_ctrl = {`IDX_CTRL_STATUS, 2'b00};
  localparam logic [9:0] a_opt = {`IDX_OPTION, 2'b00};
  localparam logic [9:0] a_st = {`IDX_STATUS, 2'b00};
  localparam logic [9:0] a_pin = {`IDX_PIN_CFG, 2'b00};
  logic clk = 0, rst = 1, avs_read = 0, avs_write = 0;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hf;
  logic [2:0] option_nv = 3'h0, option_prog_data_q;
  logic [1:0] clock_source_sel;
  logic target_in_sector0 = 0, flash_op_done = 0, mass_erase_done = 0;
  logic avs_waitrequest, prog_serial_clock_in, prog_serial_data_in;
  logic reset_pin_n, tool_present, prog_serial_clock_out;
  logic prog_serial_clock_oe, prog_serial_clock_pullup;
  logic prog_serial_data_out, prog_serial_data_oe, prog_serial_data_pullup;
  logic pins_unavailable, incircuit_comm_active, boot_system_vector;
  logic flash_op_start_q, flash_op_option_q, mass_erase_start_q;
  logic readout_block;
  int n_fail = 0, n_tests = 0, n_start = 0, n_erase = 0, cyc = 0;
  int i, base;
  int pul[4] = '{38, 38, 30, 35};
  logic [2:0] nvs[4] = '{3'h4, 3'h0, 3'h0, 3'h0};
  logic [7:0] mst[4] = '{8'h03, 8'h03, 8'h00, 8'h05};
  // pins, boot vector, session, clock source
  logic [4:0] lexp[4] = '{{3'h7, `CLK_SEL_PRECISION_RC},
    {3'h7, `CLK_SEL_WAKEUP_RC}, {3'h4, `CLK_SEL_NORMAL},
    {3'h7, `CLK_SEL_EXTERNAL}};
  wire [5:0] pin_bits = {prog_serial_clock_oe, prog_serial_clock_out,
    prog_serial_clock_pullup, prog_serial_data_oe, prog_serial_data_out,
    prog_serial_data_pullup};
  wire [4:0] link_bits = {pins_unavailable, boot_system_vector,
    incircuit_comm_active, clock_source_sel};

  flash_protect_prog_access dut_u (.clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .prog_serial_clock_in, .prog_serial_data_in,
    .reset_pin_n, .tool_present, .prog_serial_clock_out,
    .prog_serial_clock_oe, .prog_serial_clock_pullup, .prog_serial_data_out,
    .prog_serial_data_oe, .prog_serial_data_pullup, .pins_unavailable,
    .option_nv, .incircuit_comm_active, .boot_system_vector,
    .clock_source_sel, .target_in_sector0, .flash_op_start_q,
    .flash_op_option_q, .option_prog_data_q, .flash_op_done,
    .mass_erase_start_q, .mass_erase_done, .readout_block);
  prog_tool_model tool_u (.prog_serial_clock_in, .prog_serial_data_in,
    .reset_pin_n, .tool_present);

  always #2.5 clk = ~clk;
  // pulse counters and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (flash_op_start_q === 1'b1)
      n_start++;
    if (mass_erase_start_q === 1'b1)
      n_erase++;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test;
    end
  end

  task stop_test;
    begin
      $display("checks %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_tests++;
      if (seen !== exp)
      begin
        n_fail++;
        $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // request stands until waitrequest is sampled low at a rising edge;
  // read data are taken and the request dropped at that same edge
  task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task rdchk(input logic [9:0] a, input logic [7:0] e);
    begin
      bus(1'b0, a, 8'h00);
      chk(q, {24'h0, e});
    end
  endtask
  task settle;
    @(negedge clk);
  endtask
  task done_pulse(input logic erase);
    begin
      @(posedge clk);
      flash_op_done <= !erase;
      mass_erase_done <= erase;
      @(posedge clk);
      flash_op_done <= 1'b0;
      mass_erase_done <= 1'b0;
    end
  endtask
  task rst_dev(input logic [2:0] nv);
    begin
      @(posedge clk);
      rst <= 1'b1;
      option_nv <= nv;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  // keys as the programming side issues them
  task keys;
    begin
      wr(a_ctrl, `KEY_FIRST);
      wr(a_ctrl, `KEY_SECOND);
    end
  endtask

  initial
  begin
    rst_dev(3'h0);
    rdchk(a_ctrl, 8'h00);
    rdchk(10'h000, 8'h00);
    wr(a_ctrl, 8'h01);
    rdchk(a_ctrl, 8'h00);
    keys;
    rdchk(a_st, 8'h80);
    // upper bits written high must read back zero
    wr(a_ctrl, 8'hf9);
    rdchk(a_ctrl, 8'h01);
    chk(n_start, 1);
    done_pulse(1'b0);
    rdchk(a_ctrl, 8'h00);
    target_in_sector0 <= 1'b1;
    wr(a_ctrl, 8'h01);
    rdchk(a_st, 8'hc0);
    chk(n_start, 1);
    wr(a_st, 8'h40);
    target_in_sector0 <= 1'b0;
    // set the read-out lock through the option area
    wr(a_opt, 8'h01);
    wr(a_ctrl, 8'h05);
    settle;
    chk({28'h0, flash_op_option_q, option_prog_data_q}, 32'h9);
    done_pulse(1'b0);
    rdchk(a_st, 8'h88);
    wr(a_ctrl, 8'h01);
    rdchk(a_st, 8'hc8);
    chk(n_start, 2);
    wr(a_st, 8'h40);
    // lifting it must wipe the array first
    wr(a_opt, 8'h00);
    wr(a_ctrl, 8'h05);
    done_pulse(1'b0);
    settle;
    chk(n_erase, 1);
    chk({31'h0, readout_block}, 32'h1);
    done_pulse(1'b1);
    rdchk(a_st, 8'h80);
    // write lock is one-way
    wr(a_opt, 8'h02);
    wr(a_ctrl, 8'h05);
    done_pulse(1'b0);
    rdchk(a_st, 8'h90);
    settle;
    chk({31'h0, readout_block}, 32'h0);
    wr(a_ctrl, 8'h01);
    rdchk(a_st, 8'hd0);
    wr(a_st, 8'h40);
    wr(a_opt, 8'h00);
    wr(a_ctrl, 8'h05);
    done_pulse(1'b0);
    rdchk(a_st, 8'h90);
    wr(a_pin, 8'h0f);
    settle;
    chk({26'h0, pin_bits}, 32'h36);
    // locks come from the option image at each reset
    for (i = 1; i < 3; i++)
    begin
      rst_dev(i[2:0]);
      settle;
      chk({26'h0, pin_bits}, 32'h09);
      rdchk(a_st, {3'h0, i[1:0], 3'h0});
      rdchk(a_ctrl, 8'h00);
    end
    // entry modes and the clock each one forces
    for (i = 0; i < 4; i++)
    begin
      rst_dev(nvs[i]);
      wr(a_opt, {5'h0, nvs[i]});
      tool_u.enter(pul[i]);
      settle;
      chk({27'h0, link_bits}, {27'h0, lexp[i]});
      rdchk(a_st, mst[i]);
    end
    // sector 0 is open to a board-level session
    keys;
    base = n_start;
    target_in_sector0 <= 1'b1;
    wr(a_ctrl, 8'h01);
    done_pulse(1'b0);
    chk(n_start, base + 1);
    stop_test;
  end
endmodule

bind flash_protect_prog_access flash_protect_prog_access_properties chk_u (
  .clk, .rst, .prog_serial_clock_oe, .prog_serial_clock_pullup,
  .pins_unavailable, .incircuit_comm_active, .boot_system_vector,
  .clock_source_sel, .target_in_sector0, .flash_op_start_q,
  .flash_op_option_q, .mass_erase_start_q, .readout_block);
